// ### core/charger_pkg.sv
/*
  Shared constants and types for the charge sequencer: register offsets,
  field positions, reset values, timing figures, states and carriers.
  Assumes a 200 MHz single clock and an 8-bit register port.
*/
package charger_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_OPTION  = 8'h08;
  localparam logic [7:0] ADDR_THRESH  = 8'h0C;
  // Status register fields
  localparam int ST_TERM     = 0;
  localparam int ST_FASTTOUT = 1;
  localparam int ST_PRETOUT  = 2;
  localparam int ST_BATTERY_TEMP_ERROR_FLAG  = 3;
  localparam int ST_STATE_LO = 4;
  // Control register fields
  localparam int CT_ENABLE   = 0;
  localparam int CT_TIMER_EN = 1;
  localparam int CT_TERM_DIS = 2;
  localparam int CT_RESTART  = 3;
  localparam int CT_FAST_LO  = 4;
  // Option register fields
  localparam int OP_DYNAMIC_TIMER_ENABLE_BIT   = 0;
  // Threshold register fields
  localparam int TH_TERM_LO  = 0;
  localparam int TH_PRE_SEL  = 2;
  localparam int TH_ICHG_LO  = 3;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h03;
  localparam logic [7:0] OPTION_RST  = 8'h01;
  localparam logic [7:0] THRESH_RST  = 8'h01; // Termination 7.5 percent
  // Charge current as percent of the fast-charge setting
  localparam logic [7:0] PRECHG_PCT  = 8'h0A;
  localparam logic [7:0] FAST_PCT    = 8'h64;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    IDLE, DETECT, PRECHARGE, FASTCHG, CVOLT, DONE, FAULT
  } chg_state_e;
  typedef enum logic [1:0] {DET_SINK, DET_SOURCE, DET_CHECK} det_step_e;

  // Comparator and loop indications from the analog side
  typedef struct packed {
    logic batAboveLowv;
    logic batAboveRch;
    logic batAtVoreg;
    logic curBelowTerm;
    logic dppmActive;
    logic thermalActive;
    logic ppmReducing;
    logic tempFault;
    logic usbPresent;
    logic acPresent;
  } sense_s;

  // Commands to the analog charge path
  typedef struct packed {
    logic       pathOn;
    logic       cvMode;
    logic       sinkOn;
    logic       sourceOn;
    logic [7:0] currentPct;
  } drive_s;
endpackage : charger_pkg

// ### core/li_charge_ctrl.sv
/*
  Charge sequencer for a single-cell lithium charger: precharge, fast
  charge, constant voltage, termination, safety timers, battery detection.
  Assumes analog comparators arrive asynchronously on sense and that
  software uses the plain register port (read data one cycle later).
*/
// Contract
// - Charging starts in precharge at fixed 10 percent of fast current.
// - Precharge moves to fast charge when battery passes low-voltage threshold.
// - At regulation voltage enter constant voltage and hold it.
// - Current below termination threshold sets termination flag, charger off.
// - Termination is inhibited while power-path or thermal loop is active.
// - Reduced charge current makes safety timer run at half rate.
// - Termination threshold is a two-bit field, default 7.5 percent.
// - Termination disable keeps charger in constant voltage, no detection.
// - Below recharge threshold sink-test battery; if present and enabled, restart.
// - Below low-voltage in test means removed; source-test for insertion.
// - Already above recharge: sink-test again, low means no battery.
// - Detection repeats until battery found or charger disabled.
// - Battery removal raises the battery temperature error flag.
// - Separate precharge and fast timers; timer enable clear disables both.
// - Both timers are disabled while termination is disabled.
// - Half-rate timing enabled at reset, disabled by dynamic-timer bit.
// - Precharge timeout before low-voltage threshold is a timer fault.
// - Fast timeout before termination is a fault, timed from fast start.
// - Timeout flags cleared and charge restarted on supply rise, restart, recharge.
// - Temperature fault suspends charge and freezes the timer count.
`timescale 1ns/1ps
module li_charge_ctrl import charger_pkg::*; #(
  parameter int TICK_CYC   = TICK_CYCLES,
  parameter int DET_MS     = 250,
  parameter int PRE_MS0    = 1800000,
  parameter int PRE_MS1    = 3600000,
  parameter int FAST_MS0   = 10800000,
  parameter int FAST_MS1   = 18000000,
  parameter int FAST_MS2   = 21600000,
  parameter int FAST_MS3   = 28800000
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdata,
  input  wire sense_s     sense,
  output drive_s          drive,
  output logic      [1:0] termThrSel,
  output logic      [1:0] fastCurSel
);
  localparam int SW = $bits(sense_s);

  sense_s     syncA_reg, syncB_reg;
  logic       usbPrev_reg, acPrev_reg, rchPrev_reg;
  logic [7:0] control_reg, option_reg, thresh_reg;
  logic       restart_reg;
  logic       termFlag_reg, fastTout_reg, preTout_reg, battErr_reg;
  chg_state_e state_reg, state_next;
  det_step_e  step_reg;
  logic [31:0] divCnt_reg, tmr_reg, detCnt_reg;
  logic       tick_reg, halfPhase_reg;

  // Charge phases in which the safety timer and the path run
  function automatic logic isCharging(input chg_state_e s);
    return (s == PRECHARGE) || (s == FASTCHG) || (s == CVOLT);
  endfunction : isCharging

  // Two-flop synchronisers, one per comparator line
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          syncA_reg[gi] <= 1'b0;
          syncB_reg[gi] <= 1'b0;
        end else begin
          syncA_reg[gi] <= sense[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate

  sense_s s;
  assign s = syncB_reg;

  logic enable, timerEn, termDis, dynEn;
  assign enable  = control_reg[CT_ENABLE];
  assign timerEn = control_reg[CT_TIMER_EN] && !termDis;
  assign termDis = control_reg[CT_TERM_DIS];
  assign dynEn   = option_reg[OP_DYNAMIC_TIMER_ENABLE_BIT];

  // Supply rising edges and recharge falling edge for restart
  // Reset values match the idle levels, so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      usbPrev_reg <= 1'b0;
      acPrev_reg  <= 1'b0;
      rchPrev_reg <= 1'b0;
    end else begin
      usbPrev_reg <= s.usbPresent;
      acPrev_reg  <= s.acPresent;
      rchPrev_reg <= s.batAboveRch;
    end
  end

  // Only a drop below recharge restarts: a cell that timed out in precharge
  // sits below that level, and a level test would wipe the fault at once
  logic supplyRise, rchFall, restartEv;
  assign supplyRise = (s.usbPresent && !usbPrev_reg) || (s.acPresent && !acPrev_reg);
  assign rchFall    = rchPrev_reg && !s.batAboveRch;
  assign restartEv  = supplyRise || restart_reg || rchFall;

  // Register writes; restart bit is a self-clearing pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= CONTROL_RST;
      option_reg  <= OPTION_RST;
      thresh_reg  <= THRESH_RST;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wrStb && (addr == ADDR_CONTROL) && wdata[CT_RESTART];
      if (wrStb && addr == ADDR_CONTROL) begin
        control_reg <= wdata & ~(8'h01 << CT_RESTART);
      end
      if (wrStb && addr == ADDR_OPTION) begin
        option_reg <= wdata;
      end
      if (wrStb && addr == ADDR_THRESH) begin
        thresh_reg <= wdata;
      end
    end
  end

  // Read port: data stand in the cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        ADDR_STATUS:  rdata <= {1'b0, state_reg, battErr_reg, preTout_reg,
                                fastTout_reg, termFlag_reg};
        ADDR_CONTROL: rdata <= control_reg;
        ADDR_OPTION:  rdata <= option_reg;
        ADDR_THRESH:  rdata <= thresh_reg;
        default:      rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Millisecond tick divider; limits are counted in ticks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_reg <= 32'h0000_0000;
      tick_reg   <= 1'b0;
    end else if (divCnt_reg == 32'(TICK_CYC - 1)) begin
      divCnt_reg <= 32'h0000_0000;
      tick_reg   <= 1'b1;
    end else begin
      divCnt_reg <= divCnt_reg + 32'h0000_0001;
      tick_reg   <= 1'b0;
    end
  end

  // Reduced current halves the timer rate by skipping every other tick
  logic reduced, tmrTick;
  assign reduced = dynEn && (s.dppmActive || s.thermalActive || s.ppmReducing);
  assign tmrTick = tick_reg && (!reduced || halfPhase_reg);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      halfPhase_reg <= 1'b0;
    end else if (tick_reg) begin
      halfPhase_reg <= reduced ? !halfPhase_reg : 1'b0;
    end
  end

  logic [31:0] preLimit, fastLimit;
  assign preLimit = thresh_reg[TH_PRE_SEL] ? 32'(PRE_MS1) : 32'(PRE_MS0);
  always_comb begin
    case (control_reg[CT_FAST_LO +: 2])
      2'b00:   fastLimit = 32'(FAST_MS0);
      2'b01:   fastLimit = 32'(FAST_MS1);
      2'b10:   fastLimit = 32'(FAST_MS2);
      default: fastLimit = 32'(FAST_MS3);
    endcase
  end

  logic preExpired, fastExpired, termHit, detDone;
  assign preExpired  = timerEn && (tmr_reg >= preLimit);
  assign fastExpired = timerEn && (tmr_reg >= fastLimit);
  // The dppmActive and thermalActive loops would fake a taper, so they block termination; ppmReducing does not
  assign termHit = s.curBelowTerm && !s.dppmActive && !s.thermalActive
                   && !termDis;
  assign detDone = (detCnt_reg >= 32'(DET_MS));

  // Next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (enable) state_next = PRECHARGE;
      end
      PRECHARGE: begin
        if (!s.tempFault) begin
          if (s.batAboveLowv) state_next = FASTCHG;
          else if (preExpired) state_next = FAULT;
        end
      end
      FASTCHG: begin
        if (!s.tempFault) begin
          if (fastExpired) state_next = FAULT;
          else if (s.batAtVoreg) state_next = CVOLT;
        end
      end
      CVOLT: begin
        if (!s.tempFault) begin
          if (termHit) state_next = DONE;
          else if (fastExpired) state_next = FAULT;
        end
      end
      DONE: begin
        if (!s.batAboveRch && !termDis) state_next = DETECT;
      end
      DETECT: begin
        if (detDone && step_reg == DET_SINK && s.batAboveLowv) begin
          state_next = PRECHARGE;
        end else if (detDone && step_reg == DET_SOURCE && !s.batAboveRch) begin
          state_next = PRECHARGE;
        end else if (detDone && step_reg == DET_CHECK && s.batAboveLowv) begin
          state_next = PRECHARGE;
        end
      end
      FAULT: begin
        if (restartEv) state_next = PRECHARGE;
      end
      default: state_next = IDLE;
    endcase
    if (!enable) state_next = IDLE;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) state_reg <= IDLE;
    else        state_reg <= state_next;
  end

  // Detection step and its dwell counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      step_reg   <= DET_SINK;
      detCnt_reg <= 32'h0000_0000;
    end else if (state_reg != DETECT) begin
      step_reg   <= DET_SINK;
      detCnt_reg <= 32'h0000_0000;
    end else if ((step_reg != DET_SOURCE) && !s.batAboveLowv) begin
      step_reg   <= DET_SOURCE;
      detCnt_reg <= 32'h0000_0000;
    end else if (detDone && step_reg == DET_SOURCE && s.batAboveRch) begin
      step_reg   <= DET_CHECK;
      detCnt_reg <= 32'h0000_0000;
    end else if (tick_reg && !detDone) begin
      detCnt_reg <= detCnt_reg + 32'h0000_0001;
    end
  end

  // Safety timer: restarts on entering precharge and fast charge, runs on through constant voltage, freezes under temperature fault
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_reg <= 32'h0000_0000;
    end else if ((state_next == PRECHARGE && state_reg != PRECHARGE)
                 || (state_next == FASTCHG && state_reg != FASTCHG)) begin
      tmr_reg <= 32'h0000_0000;
    end else if (isCharging(state_reg) && timerEn && tmrTick && !s.tempFault) begin
      tmr_reg <= tmr_reg + 32'h0000_0001;
    end
  end

  // Status flags; a new cycle clears, termination sets
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      termFlag_reg <= 1'b0;
      fastTout_reg <= 1'b0;
      preTout_reg  <= 1'b0;
      battErr_reg  <= 1'b0;
    end else begin
      if (state_reg == CVOLT && state_next == DONE) begin
        termFlag_reg <= 1'b1;
      end else if (state_next == PRECHARGE && state_reg != PRECHARGE) begin
        termFlag_reg <= 1'b0;
      end
      if (state_reg == FAULT && state_next != FAULT) begin
        fastTout_reg <= 1'b0;
        preTout_reg  <= 1'b0;
      end else if (state_next == FAULT && state_reg == PRECHARGE) begin
        preTout_reg  <= 1'b1;
      end else if (state_next == FAULT) begin
        fastTout_reg <= 1'b1;
      end
      if (state_reg == DETECT && step_reg != DET_SOURCE && !s.batAboveLowv) begin
        battErr_reg <= 1'b1;
      end else if (state_next == PRECHARGE && state_reg == DETECT) begin
        battErr_reg <= 1'b0;
      end
    end
  end

  // Analog drive, registered; path is dropped under temperature fault
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive      <= '0;
      termThrSel <= THRESH_RST[TH_TERM_LO +: 2];
      fastCurSel <= 2'b00;
    end else begin
      termThrSel <= thresh_reg[TH_TERM_LO +: 2];
      fastCurSel <= thresh_reg[TH_ICHG_LO +: 2];
      drive.pathOn   <= isCharging(state_next) && !s.tempFault;
      drive.cvMode   <= (state_next == CVOLT);
      drive.sinkOn   <= (state_next == DETECT) && (step_reg != DET_SOURCE);
      drive.sourceOn <= (state_next == DETECT) && (step_reg == DET_SOURCE);
      if (state_next == PRECHARGE || (state_next == DETECT && step_reg == DET_SOURCE)) begin
        drive.currentPct <= PRECHG_PCT;
      end else if (isCharging(state_next)) begin
        drive.currentPct <= FAST_PCT;
      end else begin
        drive.currentPct <= 8'h00;
      end
    end
  end

  // Checks
  chk_pre_to_fast: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == PRECHARGE && s.batAboveLowv && !s.tempFault && enable
    |=> state_reg == FASTCHG)
    else $error("precharge did not advance");
  chk_pre_current: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == PRECHARGE && $past(state_reg) == PRECHARGE
    |-> drive.currentPct == PRECHG_PCT)
    else $error("precharge current wrong");
  chk_cv_entry: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == FASTCHG && s.batAtVoreg && !s.tempFault && enable && !fastExpired
    |=> state_reg == CVOLT && drive.cvMode)
    else $error("cv not entered");
  chk_term_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(termFlag_reg) |-> state_reg == DONE && !drive.pathOn)
    else $error("termination flag without done");
  chk_term_inhibit: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == CVOLT && (s.dppmActive || s.thermalActive) |=> state_reg != DONE)
    else $error("termination while loop active");
  chk_term_disable: assert property (@(posedge mclk) disable iff (!rst_b)
    termDis && state_reg == CVOLT && enable |=> state_reg inside {CVOLT})
    else $error("left cv with termination disabled");
  chk_timer_off: assert property (@(posedge mclk) disable iff (!rst_b)
    termDis && isCharging(state_reg) |=> $stable(tmr_reg) || tmr_reg == 0)
    else $error("timer ran with termination disabled");
  chk_half_rate: assert property (@(posedge mclk) disable iff (!rst_b)
    tick_reg && reduced && !halfPhase_reg && state_next == state_reg
    |=> $stable(tmr_reg))
    else $error("timer not halved under reduced current");
  chk_temp_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
    s.tempFault && isCharging(state_reg) && isCharging(state_next)
    && state_next == state_reg |=> $stable(tmr_reg) && !drive.pathOn)
    else $error("timer not frozen on temperature");
  chk_removal_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == DETECT && step_reg == DET_SINK && !s.batAboveLowv
    |=> battErr_reg && step_reg == DET_SOURCE)
    else $error("removal not flagged");
  chk_restart_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg == FAULT && restartEv && enable
    |=> !fastTout_reg && !preTout_reg && state_reg == PRECHARGE)
    else $error("fault not cleared on restart");
endmodule : li_charge_ctrl

// ### test/battery_model.sv
/*
  Behavioural single-cell battery with its analog comparators, seen from
  the charge sequencer. Assumes the sequencer's drive carrier and one clock.
*/
`timescale 1ns/1ps
module battery_model import charger_pkg::*; (
  input  wire logic   mclk,
  input  wire logic   rst_b,
  input  wire drive_s drive,
  input  wire logic   present,
  input  wire logic   stuck,
  input  wire logic   loopBusy,
  input  wire logic   hot,
  input  wire logic   acIn,
  output sense_s      sense
);
  logic [3:0] levelReg;
  logic [1:0] divReg;
  logic [4:0] taperReg;

  // Cell voltage climbs one step every four cycles while current flows
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      levelReg <= 4'h0;
      divReg   <= 2'h0;
    end else if (!present) begin
      levelReg <= 4'h0; // A removed cell loses its charge history
    end else begin
      divReg <= divReg + 2'h1;
      if (drive.pathOn && drive.currentPct != 8'h00 && !stuck && divReg == 2'h3
          && levelReg < 4'hC) begin
        levelReg <= levelReg + 4'h1;
      end
    end
  end

  // Current tapers in constant voltage; slow on purpose to leave a window
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      taperReg <= 5'h00;
    end else if (!drive.cvMode) begin
      taperReg <= 5'h00;
    end else if (taperReg != 5'h1F) begin
      taperReg <= taperReg + 5'h01;
    end
  end

  // Without a cell the pin floats high under source current, low otherwise
  always_comb begin
    sense              = '0;
    sense.batAboveLowv = present ? (levelReg >= 4'h4) : drive.sourceOn;
    sense.batAboveRch  = present ? (levelReg >= 4'hA) : drive.sourceOn;
    sense.batAtVoreg   = present && levelReg >= 4'hC;
    sense.curBelowTerm = present && taperReg == 5'h1F;
    sense.dppmActive    = loopBusy;
    sense.thermalActive = loopBusy;
    sense.ppmReducing   = loopBusy;
    sense.tempFault     = hot;
    sense.usbPresent    = 1'b1;
    sense.acPresent     = acIn;
  end
endmodule : battery_model

// ### test/test_li_charge_ctrl.sv
/*
  Self-checking bench for the charge sequencer: register port tasks and
  charge-cycle scenarios against the battery model. Assumes short timer
  parameters: 4-cycle tick, 80-cycle precharge and 240-cycle fast limits.
*/
`timescale 1ns/1ps
module test_li_charge_ctrl import charger_pkg::*;;
  logic       mclk;
  logic       rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wrStb;
  logic       rdStb;
  logic [7:0] rdata;
  sense_s     sense;
  drive_s     drive;
  logic [1:0] termThrSel;
  logic       present;
  logic       stuck;
  logic       loopBusy;
  logic [1:0] fastCurSel;
  logic       hot;
  logic       acIn;
  int         n_mismatch;
  int         checks_done;
  int         cycleCnt;

  // Only the default timer selections are used, so only those are shortened
  li_charge_ctrl #(.TICK_CYC(4), .DET_MS(3), .PRE_MS0(20), .FAST_MS0(60)) li_charge_ctrl_i (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .sense(sense), .drive(drive),
    .termThrSel(termThrSel), .fastCurSel(fastCurSel));
  battery_model battery_model_i (.mclk(mclk), .rst_b(rst_b), .drive(drive),
    .present(present), .stuck(stuck), .loopBusy(loopBusy), .hot(hot), .acIn(acIn),
    .sense(sense));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic checkVal(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : regWrite

  // Read data stand only in the cycle after the strobe edge; taken at its end
  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask : regRead

  task automatic checkReg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    regRead(a, d);
    checkVal(d & m, e);
  endtask : checkReg

  // Poll the state field, bounded so a stuck sequencer cannot hang the run
  task automatic waitState(input logic [2:0] st);
    logic [7:0] d;
    d = 8'hFF;
    for (int i = 0; i < 300 && d[6:4] !== st; i++) regRead(ADDR_STATUS, d);
    checkVal({5'h00, d[6:4]}, {5'h00, st});
  endtask : waitState

  // Hang guard: the scenarios need a few thousand cycles at most
  always @(posedge mclk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    present = 1'b1;
    stuck = 1'b1;
    loopBusy = 1'b0;
    hot = 1'b0;
    acIn = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cycleCnt = 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values; threshold left at default, the lowest one is avoided
    checkVal({4'h0, fastCurSel, termThrSel}, 8'h01);
    checkReg(ADDR_CONTROL, 8'hFF, CONTROL_RST);
    checkReg(ADDR_OPTION, 8'hFF, OPTION_RST);
    checkReg(ADDR_THRESH, 8'hFF, THRESH_RST);
    checkReg(8'h10, 8'hFF, 8'h00);
    regWrite(ADDR_OPTION, 8'h00);
    checkReg(ADDR_OPTION, 8'hFF, 8'h00);
    regWrite(ADDR_OPTION, OPTION_RST);
    // Selector outputs follow the threshold register; precharge select kept
    regWrite(ADDR_THRESH, 8'h1A);
    checkReg(ADDR_THRESH, 8'hFF, 8'h1A);
    checkVal({4'h0, fastCurSel, termThrSel}, 8'h0E);
    regWrite(ADDR_THRESH, THRESH_RST);
    // Stuck cell: precharge at a tenth, then the precharge limit trips
    waitState(PRECHARGE);
    checkVal(drive.currentPct, PRECHG_PCT);
    waitState(FAULT);
    checkReg(ADDR_STATUS, 8'h04, 8'h04);
    // Supply rise restarts; the cell is still stuck, so it times out again
    acIn <= 1'b1;
    waitState(PRECHARGE);
    checkReg(ADDR_STATUS, 8'h06, 8'h00);
    waitState(FAULT);
    checkReg(ADDR_STATUS, 8'h04, 8'h04);
    stuck <= 1'b0;
    regWrite(ADDR_CONTROL, 8'h0B);
    waitState(PRECHARGE);
    checkReg(ADDR_STATUS, 8'h06, 8'h00);
    // Full cycle with the power-path loop busy through constant voltage
    loopBusy <= 1'b1;
    waitState(FASTCHG);
    checkVal(drive.currentPct, FAST_PCT);
    waitState(CVOLT);
    checkVal({7'h00, drive.cvMode}, 8'h01);
    repeat (100) @(posedge mclk);
    checkReg(ADDR_STATUS, 8'h70, 8'h40);
    // Hot pack: path dropped, phase held until the temperature recovers
    hot <= 1'b1;
    repeat (10) @(posedge mclk);
    checkVal({7'h00, drive.pathOn}, 8'h00);
    checkReg(ADDR_STATUS, 8'h70, 8'h40);
    hot <= 1'b0;
    loopBusy <= 1'b0;
    waitState(DONE);
    checkReg(ADDR_STATUS, 8'h01, 8'h01);
    checkVal({7'h00, drive.pathOn}, 8'h00);
    // Removal: detection keeps cycling and flags the missing thermistor
    present <= 1'b0;
    waitState(DETECT);
    repeat (60) @(posedge mclk);
    checkReg(ADDR_STATUS, 8'h78, 8'h18);
    checkVal({7'h00, drive.sinkOn ^ drive.sourceOn}, 8'h01);
    present <= 1'b1;
    waitState(PRECHARGE);
    waitState(DONE);
    // Disabled charger idles; termination off holds constant voltage
    regWrite(ADDR_CONTROL, 8'h00);
    waitState(IDLE);
    regWrite(ADDR_CONTROL, 8'h07);
    waitState(CVOLT);
    repeat (300) @(posedge mclk);
    checkReg(ADDR_STATUS, 8'h76, 8'h40);
    give_verdict();
  end
endmodule : test_li_charge_ctrl
